// ===== verilog/pmc_power_monitor.sv
// power monitor: two-wire register slave, conversion sequencer, averaging and scaling
`timescale 1ns/1ps
module pmc_power_monitor #(
  parameter logic [6:0] DEV_ADDR = pmc_pkg::DEV_ADDR_DEF,
  parameter logic [15:0] DIE_IDENTIFIER = pmc_pkg::DIE_IDENTIFIER_DEF,
  parameter int CONV_CYC [8] = pmc_pkg::CONV_CYC_DEF
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // two-wire link pins, open drain
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // converter codes, valid at end of each conversion
  input wire logic [15:0] drop_code,
  input wire logic [15:0] rail_code
);
  import pmc_pkg::*;

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d;
  logic scl_rise, scl_fall, start_cond, stop_cond;
  pmc_link_t lst;
  logic [3:0] bcnt;
  logic [7:0] shreg, obyte, ptr, wr_hi, next_byte;
  logic rw, byte_lo, nack, reg_commit, cfg_hold, rd_clr, srst;
  logic [15:0] wdat, rd_word, rd_mux;
  logic [15:0] measurement_config, scaling_factor, alert_mask_flags, alert_threshold;
  logic [15:0] shunt_drop_result, rail_voltage_result, current_result, power_result;
  logic trig;
  pmc_seq_t seq;
  logic [19:0] tmr, drop_cyc, rail_cyc;
  logic [10:0] smp, avg_last;
  logic [3:0] avg_sh;
  logic [26:0] acc_drop, acc_rail;
  logic [2:0] mode;
  logic go;
  logic signed [31:0] cur_prod, pwr_prod;

  // ---------------------------------------------------------------
  // pin synchronisers and edge detection
  // ---------------------------------------------------------------
  // link pins are asynchronous; two stages before anything looks at them
  always_ff @(posedge clk) begin
    if (rst) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_d <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_s1 <= scl_in;
      scl_s2 <= scl_s1;
      scl_d <= scl_s2;
      sda_s1 <= sda_in;
      sda_s2 <= sda_s1;
      sda_d <= sda_s2;
    end
  end

  assign scl_rise = scl_s2 & ~scl_d;
  assign scl_fall = ~scl_s2 & scl_d;
  assign start_cond = scl_s2 & scl_d & sda_d & ~sda_s2;
  assign stop_cond = scl_s2 & scl_d & ~sda_d & sda_s2;

  // ---------------------------------------------------------------
  // register read mux
  // ---------------------------------------------------------------
  // a read selects a value, and a read of pointer 6 also clears the ready flag; nothing here alters settings
  always_comb begin
    case (ptr)
      PTR_CFG: rd_mux = measurement_config;
      PTR_DROP: rd_mux = shunt_drop_result;
      PTR_RAIL: rd_mux = rail_voltage_result;
      PTR_POWER: rd_mux = power_result;
      PTR_CURRENT: rd_mux = current_result;
      PTR_SCALE: rd_mux = scaling_factor;
      PTR_MASK: rd_mux = alert_mask_flags;
      PTR_LIMIT: rd_mux = alert_threshold;
      PTR_ID: rd_mux = DIE_IDENTIFIER;
      default: rd_mux = ZERO_RESET;
    endcase
  end

  assign next_byte = byte_lo ? rd_word[15:8] : rd_word[7:0];

  // ---------------------------------------------------------------
  // two-wire slave: address, pointer, then byte pairs
  // ---------------------------------------------------------------
  // data is taken on scl rise and driven on scl fall, so sda is stable while scl is high
  always_ff @(posedge clk) begin
    if (rst) begin
      lst <= I2C_IDLE;
      bcnt <= 4'h0;
      shreg <= 8'h00;
      obyte <= 8'h00;
      ptr <= PTR_CFG;
      wr_hi <= 8'h00;
      rw <= 1'b0;
      byte_lo <= 1'b0;
      nack <= 1'b0;
      reg_commit <= 1'b0;
      cfg_hold <= 1'b0;
      rd_clr <= 1'b0;
      wdat <= ZERO_RESET;
      rd_word <= ZERO_RESET;
      sda_oe <= 1'b0;
      sda_out <= 1'b0;
    end else begin
      reg_commit <= 1'b0;
      rd_clr <= 1'b0;
      sda_out <= 1'b0;
      if (start_cond) begin
        lst <= I2C_ADDR;
        bcnt <= 4'h0;
        sda_oe <= 1'b0;
        cfg_hold <= 1'b0;
      end else if (stop_cond) begin
        lst <= I2C_IDLE;
        sda_oe <= 1'b0;
        cfg_hold <= 1'b0;
      end else if (scl_rise) begin
        if ((lst == I2C_ADDR || lst == I2C_PTR || lst == I2C_WDAT) && bcnt != 4'h8) begin
          shreg <= {shreg[6:0], sda_s2};
          bcnt <= bcnt + 4'h1;
        end
        if (lst == I2C_RACK) begin
          nack <= sda_s2;
        end
      end else if (scl_fall) begin
        case (lst)
          I2C_ADDR: begin
            if (bcnt == 4'h8) begin
              if (shreg[7:1] == DEV_ADDR) begin
                sda_oe <= 1'b1;
                rw <= shreg[0];
                lst <= I2C_ACK_A;
              end else begin
                lst <= I2C_IDLE;
              end
            end
          end
          I2C_ACK_A: begin
            byte_lo <= 1'b0;
            if (rw) begin
              // high byte goes first
              rd_word <= rd_mux;
              rd_clr <= (ptr == PTR_MASK);
              sda_oe <= ~rd_mux[15];
              obyte <= {rd_mux[14:8], 1'b0};
              bcnt <= 4'h1;
              lst <= I2C_RDAT;
            end else begin
              sda_oe <= 1'b0;
              bcnt <= 4'h0;
              lst <= I2C_PTR;
            end
          end
          I2C_PTR: begin
            if (bcnt == 4'h8) begin
              sda_oe <= 1'b1;
              ptr <= shreg;
              lst <= I2C_ACK_P;
            end
          end
          I2C_ACK_P: begin
            sda_oe <= 1'b0;
            bcnt <= 4'h0;
            byte_lo <= 1'b0;
            lst <= I2C_WDAT;
          end
          I2C_WDAT: begin
            if (bcnt == 4'h8) begin
              sda_oe <= 1'b1;
              lst <= I2C_ACK_W;
              if (!byte_lo) begin
                wr_hi <= shreg;
                cfg_hold <= (ptr == PTR_CFG);
              end else begin
                reg_commit <= 1'b1;
                wdat <= {wr_hi, shreg};
                cfg_hold <= 1'b0;
              end
            end
          end
          I2C_ACK_W: begin
            sda_oe <= 1'b0;
            bcnt <= 4'h0;
            byte_lo <= ~byte_lo;
            lst <= I2C_WDAT;
          end
          I2C_RDAT: begin
            if (bcnt == 4'h8) begin
              sda_oe <= 1'b0;
              lst <= I2C_RACK;
            end else begin
              sda_oe <= ~obyte[7];
              obyte <= {obyte[6:0], 1'b0};
              bcnt <= bcnt + 4'h1;
            end
          end
          I2C_RACK: begin
            // a nack ends the read; an ack keeps alternating bytes of the same word
            if (nack) begin
              lst <= I2C_IDLE;
            end else begin
              byte_lo <= ~byte_lo;
              sda_oe <= ~next_byte[7];
              obyte <= {next_byte[6:0], 1'b0};
              bcnt <= 4'h1;
              lst <= I2C_RDAT;
            end
          end
          default: lst <= I2C_IDLE;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // writable registers and soft reset
  // ---------------------------------------------------------------
  // soft reset is one cycle after the write so the link finishes its acknowledge
  always_ff @(posedge clk) begin
    if (rst) begin
      srst <= 1'b0;
    end else begin
      srst <= reg_commit && ptr == PTR_CFG && wdat[CFG_SRST_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (rst || srst) begin
      measurement_config <= CFG_RESET;
      scaling_factor <= ZERO_RESET;
      alert_mask_flags <= ZERO_RESET;
      alert_threshold <= ZERO_RESET;
      trig <= 1'b0;
    end else begin
      if (reg_commit) begin
        case (ptr)
          PTR_CFG: measurement_config <= (wdat & CFG_WMASK) | CFG_FIXED;
          PTR_SCALE: scaling_factor <= wdat & SCALE_WMASK;
          PTR_MASK: alert_mask_flags <= (wdat & MASK_WMASK) | (alert_mask_flags & ~MASK_WMASK);
          PTR_LIMIT: alert_threshold <= wdat;
          default: ;
        endcase
      end
      // ready flag: set by a finished block, cleared by reading pointer 6, set wins
      alert_mask_flags[READY_BIT] <= (seq == SEQ_PWR) | (alert_mask_flags[READY_BIT] & ~rd_clr);
      // a triggered mode runs one block per configuration write
      if (reg_commit && ptr == PTR_CFG) begin
        trig <= 1'b1;
      end else if (seq == SEQ_PWR) begin
        trig <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // conversion sequencer
  // ---------------------------------------------------------------
  assign mode = measurement_config[MODE_LSB +: 3];
  assign avg_sh = 4'(AVG_SHIFT[measurement_config[AVG_LSB +: 3]]);
  assign avg_last = 11'((32'd1 << avg_sh) - 32'd1);
  assign drop_cyc = 20'(CONV_CYC[measurement_config[DROP_CT_LSB +: 3]] - 1);
  assign rail_cyc = 20'(CONV_CYC[measurement_config[RAIL_CT_LSB +: 3]] - 1);
  assign go = (mode[1:0] != 2'b00) && (mode[2] || trig);

  // a configuration write throws away the partial block so no sample mixes settings
  always_ff @(posedge clk) begin
    if (rst || srst) begin
      seq <= SEQ_IDLE;
      tmr <= 20'h00000;
      smp <= 11'h000;
      acc_drop <= 27'h0000000;
      acc_rail <= 27'h0000000;
    end else if (cfg_hold || (reg_commit && ptr == PTR_CFG)) begin
      seq <= SEQ_IDLE;
      smp <= 11'h000;
      acc_drop <= 27'h0000000;
      acc_rail <= 27'h0000000;
    end else begin
      case (seq)
        SEQ_IDLE: begin
          if (go) begin
            seq <= mode[0] ? SEQ_DROP : SEQ_RAIL;
            tmr <= mode[0] ? drop_cyc : rail_cyc;
          end
        end
        SEQ_DROP: begin
          if (tmr == 20'h00000) begin
            acc_drop <= acc_drop + {{11{drop_code[15]}}, drop_code};
            seq <= mode[1] ? SEQ_RAIL : SEQ_NEXT;
            tmr <= rail_cyc;
          end else begin
            tmr <= tmr - 20'h00001;
          end
        end
        SEQ_RAIL: begin
          if (tmr == 20'h00000) begin
            acc_rail <= acc_rail + {{11{rail_code[15]}}, rail_code};
            seq <= SEQ_NEXT;
          end else begin
            tmr <= tmr - 20'h00001;
          end
        end
        SEQ_NEXT: begin
          if (smp == avg_last) begin
            smp <= 11'h000;
            seq <= SEQ_VOLT;
          end else begin
            smp <= smp + 11'h001;
            seq <= SEQ_IDLE;
          end
        end
        SEQ_VOLT: begin
          acc_drop <= 27'h0000000;
          acc_rail <= 27'h0000000;
          seq <= SEQ_CURR;
        end
        SEQ_CURR: seq <= SEQ_PWR;
        SEQ_PWR: seq <= SEQ_IDLE;
        default: seq <= SEQ_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // result registers
  // ---------------------------------------------------------------
  // scaling is 15 bits, so zero-extending keeps the product signed and exact
  assign cur_prod = $signed(shunt_drop_result) * $signed({1'b0, scaling_factor[14:0]});
  assign pwr_prod = $signed(current_result) * $signed({1'b0, rail_voltage_result[14:0]});

  always_ff @(posedge clk) begin
    if (rst || srst) begin
      shunt_drop_result <= ZERO_RESET;
      rail_voltage_result <= ZERO_RESET;
      current_result <= ZERO_RESET;
      power_result <= ZERO_RESET;
    end else begin
      if (seq == SEQ_VOLT && mode[0]) begin
        shunt_drop_result <= 16'($signed(acc_drop) >>> avg_sh);
      end
      if (seq == SEQ_VOLT && mode[1]) begin
        rail_voltage_result <= 16'($signed(acc_rail) >>> avg_sh);
      end
      if (seq == SEQ_CURR) begin
        current_result <= 16'(cur_prod >>> CUR_SHIFT);
      end
      if (seq == SEQ_PWR) begin
        power_result <= 16'(pwr_prod / PWR_DIV);
      end
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  property p_cfg_fixed;
    measurement_config[15:12] == 4'h4;
  endproperty
  a_cfg_fixed: assert property (p_cfg_fixed) else $error("fixed config bits wrong");

  property p_soft_reset;
    (reg_commit && ptr == PTR_CFG && wdat[CFG_SRST_BIT]) |-> ##2 (measurement_config == CFG_RESET
      && scaling_factor == ZERO_RESET && power_result == ZERO_RESET);
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset did not restore defaults");

  property p_cfg_stable;
    !(reg_commit && ptr == PTR_CFG) && !srst |=> $stable(measurement_config);
  endproperty
  a_cfg_stable: assert property (p_cfg_stable) else $error("config changed without a write");

  property p_hold_halts;
    cfg_hold |=> seq == SEQ_IDLE && acc_drop == 27'h0000000;
  endproperty
  a_hold_halts: assert property (p_hold_halts) else $error("conversion ran during config write");

  property p_zero_scale;
    (seq == SEQ_CURR && scaling_factor == ZERO_RESET) |=> ##1 (current_result == ZERO_RESET
      && power_result == ZERO_RESET);
  endproperty
  a_zero_scale: assert property (p_zero_scale) else $error("nonzero current with zero scaling");

  property p_result_hold;
    seq != SEQ_VOLT && !srst |=> $stable(shunt_drop_result) && $stable(rail_voltage_result);
  endproperty
  a_result_hold: assert property (p_result_hold) else $error("result changed mid block");

  property p_power_down;
    (seq == SEQ_IDLE && mode[1:0] == 2'b00) |=> seq == SEQ_IDLE;
  endproperty
  a_power_down: assert property (p_power_down) else $error("conversion started in power-down");

  property p_ro_ignored;
    (reg_commit && ptr == PTR_CURRENT) |=> $stable(current_result) || $past(seq) == SEQ_CURR;
  endproperty
  a_ro_ignored: assert property (p_ro_ignored) else $error("write reached a read-only register");

  property p_ready_set;
    (seq == SEQ_PWR) |=> alert_mask_flags[READY_BIT] && seq == SEQ_IDLE;
  endproperty
  a_ready_set: assert property (p_ready_set) else $error("ready flag not set after block");

endmodule : pmc_power_monitor

// ===== inc/pmc_pkg.sv
// constants, encodings and state types for the power monitor register block
// Operation
// - defaults convert shunt and bus continuously
// - zero scaling gives zero current and power
// - pointer selects register, ff is identifier
// - configuration resets to 4127, read/write
// - results read-only zero, others read/write zero
// - each register moves as two bytes
// - configuration read disturbs nothing
// - configuration write halts, then restarts conversion
// - bit 15 write resets all, self-clears
// - averaging code selects 1 to 1024 samples
// - bus time code selects 140us to 8.244ms
// - fixed configuration bits and field layout
// - mode selects which signals convert
// - scaling sets current and power weight
// - pointer 6 holds alert setup, ready flag
// - mode codes: power-down, triggered, continuous
// - shunt time uses same eight times
// - current is shunt times scaling over 2048
// - power is current times bus over 20000
package pmc_pkg;

  // ---------------------------------------------------------------
  // register pointers
  // ---------------------------------------------------------------
  localparam logic [7:0] PTR_CFG = 8'h00;
  localparam logic [7:0] PTR_DROP = 8'h01;
  localparam logic [7:0] PTR_RAIL = 8'h02;
  localparam logic [7:0] PTR_POWER = 8'h03;
  localparam logic [7:0] PTR_CURRENT = 8'h04;
  localparam logic [7:0] PTR_SCALE = 8'h05;
  localparam logic [7:0] PTR_MASK = 8'h06;
  localparam logic [7:0] PTR_LIMIT = 8'h07;
  localparam logic [7:0] PTR_ID = 8'hff;

  // ---------------------------------------------------------------
  // reset values and field layout
  // ---------------------------------------------------------------
  localparam logic [15:0] CFG_RESET = 16'h4127;
  localparam logic [15:0] ZERO_RESET = 16'h0000;
  localparam logic [15:0] CFG_FIXED = 16'h4000;
  localparam logic [15:0] CFG_WMASK = 16'h0fff;
  localparam logic [15:0] SCALE_WMASK = 16'h7fff;
  localparam logic [15:0] MASK_WMASK = 16'hfc17;
  localparam int CFG_SRST_BIT = 15;
  localparam int AVG_LSB = 9;
  localparam int RAIL_CT_LSB = 6;
  localparam int DROP_CT_LSB = 3;
  localparam int MODE_LSB = 0;
  localparam int READY_BIT = 3;
  localparam int CUR_SHIFT = 11;
  localparam int PWR_DIV = 20000;
  localparam logic [6:0] DEV_ADDR_DEF = 7'h40;  // arbitrary bus address
  localparam logic [15:0] DIE_IDENTIFIER_DEF = 16'h5a5a;  // arbitrary identifier value

  // averaging: count is 1 << shift
  localparam int AVG_SHIFT [8] = '{0, 2, 4, 6, 7, 8, 9, 10};

  // ---------------------------------------------------------------
  // conversion times
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int CONV_TIME_NS [8] = '{140000, 204000, 332000, 588000, 1100000, 2116000, 4156000, 8244000};
  localparam int CONV_CYC_DEF [8] = '{
    CONV_TIME_NS[0] / CLK_PERIOD_NS, CONV_TIME_NS[1] / CLK_PERIOD_NS,
    CONV_TIME_NS[2] / CLK_PERIOD_NS, CONV_TIME_NS[3] / CLK_PERIOD_NS,
    CONV_TIME_NS[4] / CLK_PERIOD_NS, CONV_TIME_NS[5] / CLK_PERIOD_NS,
    CONV_TIME_NS[6] / CLK_PERIOD_NS, CONV_TIME_NS[7] / CLK_PERIOD_NS};

  // ---------------------------------------------------------------
  // state types
  // ---------------------------------------------------------------
  typedef enum logic [8:0] {
    I2C_IDLE = 9'h001, I2C_ADDR = 9'h002, I2C_ACK_A = 9'h004, I2C_PTR = 9'h008, I2C_ACK_P = 9'h010,
    I2C_WDAT = 9'h020, I2C_ACK_W = 9'h040, I2C_RDAT = 9'h080, I2C_RACK = 9'h100
  } pmc_link_t;

  typedef enum logic [6:0] {
    SEQ_IDLE = 7'h01, SEQ_DROP = 7'h02, SEQ_RAIL = 7'h04, SEQ_NEXT = 7'h08,
    SEQ_VOLT = 7'h10, SEQ_CURR = 7'h20, SEQ_PWR = 7'h40
  } pmc_seq_t;

endpackage : pmc_pkg

// ===== test/pmc_host_model.sv
// two-wire host model that reads and writes the monitor's registers
`timescale 1ns/1ps
module pmc_host_model
  import pmc_pkg::*;
(
  // clock
  input wire logic clk,
  // link pins, open drain
  output logic scl,
  output logic sda_low,
  input wire logic sda_line
);
  // ---------------------------------------------------------------
  // bit level
  // ---------------------------------------------------------------
  // link clock idles high; data released so the pull-up holds the line
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // twelve ticks make one 125 ns link bit, free of clk so the synchronisers see a truly foreign clock
  task automatic tick(input int n);
    #(n * 125.0 / 12.0);
  endtask : tick

  // data moves mid-low, so the slave never sees it change under a high clock
  task automatic put_bit(input logic b);
    sda_low = ~b;
    tick(3);
    scl = 1'b1;
    tick(6);
    scl = 1'b0;
    tick(3);
  endtask : put_bit

  task automatic get_bit(output logic b);
    sda_low = 1'b0;
    tick(3);
    scl = 1'b1;
    tick(3);
    b = sda_line;
    tick(3);
    scl = 1'b0;
    tick(3);
  endtask : get_bit

  task automatic start_cond();
    @(negedge clk);
    sda_low = 1'b0;
    scl = 1'b1;
    tick(3);
    sda_low = 1'b1;
    tick(3);
    scl = 1'b0;
    tick(3);
  endtask : start_cond

  task automatic stop_cond();
    sda_low = 1'b1;
    tick(3);
    scl = 1'b1;
    tick(3);
    sda_low = 1'b0;
    tick(6);
  endtask : stop_cond

  // ---------------------------------------------------------------
  // byte and register level
  // ---------------------------------------------------------------
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) put_bit(d[i]);
    get_bit(b);
    ack = ~b;
  endtask : send_byte

  // the final byte is refused so the slave lets go of the line
  task automatic recv_byte(input logic last, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) get_bit(d[i]);
    put_bit(last);
  endtask : recv_byte

  task automatic write_reg(input logic [7:0] ptr, input logic [15:0] d, output logic ack);
    logic a0, a1, a2, a3;
    start_cond();
    send_byte({DEV_ADDR_DEF, 1'b0}, a0);
    send_byte(ptr, a1);
    send_byte(d[15:8], a2);
    send_byte(d[7:0], a3);
    stop_cond();
    ack = a0 & a1 & a2 & a3;
  endtask : write_reg

  // pointer set in its own frame, then a read frame uses it
  task automatic read_reg(input logic [7:0] ptr, output logic [15:0] d);
    logic a;
    start_cond();
    send_byte({DEV_ADDR_DEF, 1'b0}, a);
    send_byte(ptr, a);
    stop_cond();
    start_cond();
    send_byte({DEV_ADDR_DEF, 1'b1}, a);
    recv_byte(1'b0, d[15:8]);
    recv_byte(1'b1, d[7:0]);
    stop_cond();
  endtask : read_reg
endmodule : pmc_host_model

// ===== test/tb.sv
// self-checking testbench for the power monitor register block
`timescale 1ns/1ps
module tb;
  import pmc_pkg::*;
  // short conversions keep the run brief
  localparam int SIM_CYC [8] = '{20, 21, 22, 23, 24, 25, 26, 27};
  logic clk, rst, scl, host_low, sda_out, sda_oe, sda_line;
  logic [15:0] drop_code, rail_code;
  int n_fail = 0;
  int num_checks = 0;

  // wired-and data line with pull-up
  assign sda_line = ~((sda_oe & ~sda_out) | host_low);

  pmc_power_monitor #(.CONV_CYC(SIM_CYC)) u_pmc_power_monitor (
    .clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe(sda_oe), .drop_code(drop_code), .rail_code(rail_code));
  pmc_host_model u_pmc_host_model (.clk(clk), .scl(scl), .sda_low(host_low), .sda_line(sda_line));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk);
  endtask : wait_clk

  task automatic wr(input logic [7:0] ptr, input logic [15:0] d);
    logic a;
    u_pmc_host_model.write_reg(ptr, d, a);
    @(negedge clk);
  endtask : wr

  task automatic rd_chk(input logic [7:0] ptr, input logic [15:0] exp);
    logic [15:0] v;
    u_pmc_host_model.read_reg(ptr, v);
    @(negedge clk);
    check(v, exp);
  endtask : rd_chk

  task automatic set_codes(input logic [15:0] d, input logic [15:0] r);
    drop_code = d;
    rail_code = r;
  endtask : set_codes

  task automatic give_verdict();
    $display("checks=%0d errors=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  // zero codes keep results at reset level; the ready flag is already up from the first block
  task automatic t_defaults();
    check(16'(sda_out), 16'h0000);
    rd_chk(PTR_CFG, 16'h4127);
    for (int p = 1; p < 8; p++) rd_chk(8'(p), (p == 6) ? 16'h0008 : 16'h0000);
    rd_chk(PTR_ID, DIE_IDENTIFIER_DEF);
  endtask : t_defaults

  task automatic t_plain();
    set_codes(16'h1f40, 16'h2570);
    wait_clk(200);
    rd_chk(PTR_DROP, 16'h1f40);
    rd_chk(PTR_RAIL, 16'h2570);
    rd_chk(PTR_CURRENT, 16'h0000);
    rd_chk(PTR_POWER, 16'h0000);
  endtask : t_plain

  // 8000 * 2560 / 2048 = 10000; 10000 * 9584 / 20000 = 4792
  task automatic t_scale();
    wr(PTR_SCALE, 16'h0a00);
    wait_clk(200);
    rd_chk(PTR_SCALE, 16'h0a00);
    rd_chk(PTR_CURRENT, 16'd10000);
    rd_chk(PTR_POWER, 16'd4792);
  endtask : t_scale

  task automatic t_fixed();
    wr(PTR_CFG, 16'h3327);
    rd_chk(PTR_CFG, 16'h4327);
    wr(PTR_DROP, 16'hffff);
    rd_chk(PTR_DROP, 16'h1f40);
    wr(PTR_CURRENT, 16'hffff);
    rd_chk(PTR_CURRENT, 16'd10000);
    wr(PTR_LIMIT, 16'h1234);
    rd_chk(PTR_LIMIT, 16'h1234);
    wr(PTR_SCALE, 16'hffff);
    rd_chk(PTR_SCALE, 16'h7fff);
  endtask : t_fixed

  // rail-only, power-down, shunt-only and triggered modes decide which result follows the converter codes
  task automatic t_modes();
    wr(PTR_CFG, 16'h4126);
    set_codes(16'h0100, 16'h1000);
    wait_clk(300);
    rd_chk(PTR_DROP, 16'h1f40);
    rd_chk(PTR_RAIL, 16'h1000);
    wr(PTR_CFG, 16'h4120);
    set_codes(16'h0100, 16'h0800);
    wait_clk(300);
    rd_chk(PTR_RAIL, 16'h1000);
    wr(PTR_CFG, 16'h4125);
    wait_clk(300);
    rd_chk(PTR_DROP, 16'h0100);
    rd_chk(PTR_RAIL, 16'h1000);
    wr(PTR_CFG, 16'h4124);
    set_codes(16'h0200, 16'h0400);
    wr(PTR_CFG, 16'h4123);
    wait_clk(300);
    rd_chk(PTR_DROP, 16'h0200);
    rd_chk(PTR_RAIL, 16'h0400);
    set_codes(16'h0300, 16'h0500);
    wait_clk(300);
    rd_chk(PTR_DROP, 16'h0200);
    rd_chk(PTR_CFG, 16'h4123);
  endtask : t_modes

  task automatic t_soft_reset();
    wr(PTR_CFG, 16'h8000);
    wait_clk(10);
    rd_chk(PTR_CFG, 16'h4127);
    rd_chk(PTR_SCALE, 16'h0000);
    rd_chk(PTR_LIMIT, 16'h0000);
    // host writes scaling 0a00 again after the reset cleared it
    wr(PTR_SCALE, 16'h0a00);
    rd_chk(PTR_SCALE, 16'h0a00);
  endtask : t_soft_reset

  // ---------------------------------------------------------------
  // clock, sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    rst = 1'b1;
    set_codes(16'h0000, 16'h0000);
    wait_clk(4);
    rst = 1'b0;
    wait_clk(4);
    t_defaults();
    t_plain();
    t_scale();
    t_fixed();
    t_modes();
    t_soft_reset();
    give_verdict();
  end

  // a hung link would otherwise never end the run; traffic needs about 30,000 cycles, limit is 60,000
  initial begin
    #600_000;
    n_fail++;
    give_verdict();
  end
endmodule : tb
